// file: rtl/lvsup_pkg.sv
// constants for the line voltage supervisor
package lvsup_pkg;
  localparam logic [5:0]  ADDR_ZERO_CROSS_TIMEOUT    = 6'h1D;
  localparam logic [5:0]  ADDR_PERIOD    = 6'h27;
  localparam logic [5:0]  ADDR_DIPLVL    = 6'h1F;
  localparam logic [5:0]  ADDR_DIPCYC    = 6'h1E;
  localparam logic [5:0]  ADDR_OFFSET    = 6'h0D;
  localparam logic [5:0]  ADDR_MODE      = 6'h09;
  localparam logic [5:0]  ADDR_IRQEN     = 6'h0A;
  localparam logic [5:0]  ADDR_STATUS    = 6'h0B;
  localparam logic [5:0]  ADDR_STATCLR   = 6'h0C;
  localparam int          MODE_DIPDIS    = 0;
  localparam int          OFS_INTEG      = 7;
  localparam int          ST_DIP         = 0;
  localparam int          ST_CROSSING_TIMEOUT_FLAG        = 1;
  localparam int          ST_ZX          = 2;
  localparam logic [11:0] ZERO_CROSS_TIMEOUT_RST     = 12'hFFF;
  localparam logic [7:0]  DIPLVL_RST     = 8'h2D;
  localparam logic [7:0]  DIPCYC_RST     = 8'hFF;
  localparam logic [15:0] IRQEN_RST      = 16'h0000;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam int          TO_DIV         = 128;
  localparam int          PER_DIV        = 32;
  localparam int          FILT_SHIFT     = 3;
endpackage : lvsup_pkg

// file: rtl/lvsup_top.sv
// line voltage supervisor: crossing, timeout, period, dip, status
`timescale 1ns/1ps
module lvsup_top #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // voltage channel filtered samples
  input  wire logic                i_smp_valid,
  input  wire logic [SAMPLE_W-1:0] i_smp,
  // supply monitor
  input  wire logic                i_undervolt,
  // register port
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  input  wire logic [5:0]          i_addr,
  input  wire logic [15:0]         i_wdata,
  output logic      [15:0]         o_rdata,
  // pins and controls
  output logic                     o_zero_cross_out,
  output logic                     o_dip_n,
  output logic                     o_irq_n,
  output logic                     o_integrator_en,
  output logic                     o_accum_en
);
  import lvsup_pkg::*;

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0]  offset;
    logic [7:0]  mode;
    logic [15:0] irqen;
    logic [2:0]  status;
    logic [11:0] zero_cross_timeout;
    logic [11:0] to_cnt;
    logic        to_done;
    logic [7:0]  dip_level;
    logic [7:0]  dip_cyc;
    logic [7:0]  cyc_cnt;
    logic        dip_act;
    logic        zx;
    logic        seen;
    logic [6:0]  div128;
    logic [4:0]  div32;
    logic [15:0] per_cnt;
    logic [18:0] per_acc;
    logic [15:0] period;
    logic [15:0] rdata;
  } lvsup_state_t;

  lvsup_state_t s_reg;
  lvsup_state_t s_next;

  logic              smp_pos;
  logic [7:0]        msb_byte;
  logic [7:0]        abs_byte;
  logic [7:0]        thresh;
  logic              below;
  logic              zx_event;
  logic              rise;
  logic              tick128;
  logic              tick32;
  logic [15:0]       per_filt;
  logic              to_expire;

  // ----------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------
  // counter has hit zero and no crossing rearms it this cycle
  function automatic logic expiry_due(input logic       ev,
                                      input logic [11:0] cnt,
                                      input logic       done);
    expiry_due = !ev && (cnt == 12'h000) && !done;
  endfunction : expiry_due

  // ----------------------------------------------------------
  // sample decode
  // ----------------------------------------------------------
  always_comb
  begin
    smp_pos  = ~i_smp[SAMPLE_W-1];
    msb_byte = i_smp[SAMPLE_W-2 -: 8];
    abs_byte = msb_byte[7] ? 8'(~msb_byte + 8'h01) : msb_byte;
    thresh   = (s_reg.dip_level <= 8'h01) ? 8'h00 : s_reg.dip_level;
    below    = thresh > abs_byte;
    zx_event = i_smp_valid && s_reg.seen && (smp_pos != s_reg.zx);
    rise     = zx_event && smp_pos;
    tick128  = (s_reg.div128 == 7'(TO_DIV - 1));
    tick32   = (s_reg.div32 == 5'(PER_DIV - 1));
    per_filt = s_reg.per_acc[18:3];
    to_expire = expiry_due(zx_event, s_reg.to_cnt, s_reg.to_done);
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.div128 = 7'(s_reg.div128 + 7'h01);
    s_next.div32  = 5'(s_reg.div32 + 5'h01);
    if (i_smp_valid)
    begin
      s_next.seen = 1'b1;
      s_next.zx   = smp_pos;
    end
    // timeout
    if (zx_event)
    begin
      s_next.to_cnt  = s_reg.zero_cross_timeout;
      s_next.to_done = 1'b0;
    end
    else if (tick128 && s_reg.to_cnt != 12'h000)
    begin
      s_next.to_cnt = 12'(s_reg.to_cnt - 12'h001);
    end
    if (to_expire)
    begin
      s_next.to_done = 1'b1;
    end
    // period
    if (tick32 && s_reg.per_cnt != 16'h7FFF)
    begin
      s_next.per_cnt = 16'(s_reg.per_cnt + 16'h0001);
    end
    if (rise)
    begin
      s_next.per_cnt = 16'h0000;
      s_next.per_acc = 19'(s_reg.per_acc - {3'h0, per_filt} + {3'h0, s_reg.per_cnt});
      s_next.period  = {1'b0, per_filt[14:0]};
    end
    // dip detection
    if (i_smp_valid && !below)
    begin
      s_next.cyc_cnt = 8'h00;
      s_next.dip_act = 1'b0;
    end
    else if (rise && below)
    begin
      if (8'(s_reg.cyc_cnt + 8'h01) >= 8'(s_reg.dip_cyc - 8'h01))
      begin
        s_next.dip_act = 1'b1;
      end
      else
      begin
        s_next.cyc_cnt = 8'(s_reg.cyc_cnt + 8'h01);
      end
    end
    // register writes
    if (i_wr)
    begin
      case (i_addr)
        ADDR_ZERO_CROSS_TIMEOUT: s_next.zero_cross_timeout    = i_wdata[11:0];
        ADDR_DIPLVL: s_next.dip_level = i_wdata[7:0];
        ADDR_DIPCYC: s_next.dip_cyc   = i_wdata[7:0];
        ADDR_OFFSET: s_next.offset    = i_wdata[7:0];
        ADDR_MODE:   s_next.mode      = i_wdata[7:0];
        ADDR_IRQEN:  s_next.irqen     = i_wdata;
        default:     s_next.offset    = s_next.offset;
      endcase
    end
    // read data
    if (i_rd)
    begin
      case (i_addr)
        ADDR_ZERO_CROSS_TIMEOUT:  s_next.rdata = {4'h0, s_reg.zero_cross_timeout};
        ADDR_PERIOD:  s_next.rdata = s_reg.period;
        ADDR_DIPLVL:  s_next.rdata = {8'h00, s_reg.dip_level};
        ADDR_DIPCYC:  s_next.rdata = {8'h00, s_reg.dip_cyc};
        ADDR_OFFSET:  s_next.rdata = {8'h00, s_reg.offset};
        ADDR_MODE:    s_next.rdata = {8'h00, s_reg.mode};
        ADDR_IRQEN:   s_next.rdata = s_reg.irqen;
        ADDR_STATUS:  s_next.rdata = {13'h0000, s_reg.status};
        ADDR_STATCLR: s_next.rdata = {13'h0000, s_reg.status};
        default:      s_next.rdata = 16'h0000;
      endcase
      if (i_addr == ADDR_STATCLR)
      begin
        s_next.status = 3'b000;
      end
    end
    // event flags, set wins over clear
    if (zx_event)
    begin
      s_next.status[ST_ZX] = 1'b1;
    end
    if (to_expire)
    begin
      s_next.status[ST_CROSSING_TIMEOUT_FLAG] = 1'b1;
    end
    if (s_next.dip_act && !s_reg.dip_act)
    begin
      s_next.status[ST_DIP] = 1'b1;
    end
  end

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_reg           <= '0;
      s_reg.zero_cross_timeout    <= ZERO_CROSS_TIMEOUT_RST;
      s_reg.to_cnt    <= ZERO_CROSS_TIMEOUT_RST;
      s_reg.dip_level <= DIPLVL_RST;
      s_reg.dip_cyc   <= DIPCYC_RST;
      s_reg.irqen     <= IRQEN_RST;
      s_reg.mode      <= MODE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign o_rdata          = s_reg.rdata;
  assign o_zero_cross_out = s_reg.zx;
  assign o_integrator_en  = s_reg.offset[OFS_INTEG];
  assign o_accum_en       = ~i_undervolt;
  assign o_irq_n          = ~(|(s_reg.status & s_reg.irqen[2:0]));
  assign o_dip_n          = ~(i_undervolt
                              || (!s_reg.mode[MODE_DIPDIS]
                                  && (s_reg.to_done || s_reg.dip_act)));

endmodule : lvsup_top

// file: sim/lvsup_top_monitor.sv
// port assertions for the line voltage supervisor
`timescale 1ns/1ps
module lvsup_top_monitor import lvsup_pkg::*; #(parameter int SAMPLE_W = 16) (
  input wire logic i_clk, i_rst, i_smp_valid, i_undervolt, i_wr, i_rd, o_zero_cross_out,
  input wire logic o_dip_n, o_irq_n, o_integrator_en, o_accum_en,
  input wire logic [SAMPLE_W-1:0] i_smp,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata, o_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd(a); i_rd && i_addr == a; endsequence
  sequence s_ofs; i_wr && i_addr == ADDR_OFFSET; endsequence
  a_accum_halt: assert property (o_accum_en == !i_undervolt) else $error("accum");
  a_uv_dip: assert property (i_undervolt |-> !o_dip_n) else $error("uv dip");
  a_integ_set: assert property (s_ofs |=> o_integrator_en == $past(i_wdata[7])) else $error("integ");
  a_integ_hold: assert property (!(i_wr && i_addr == ADDR_OFFSET) |=> $stable(o_integrator_en)) else $error("ih");
  a_zx_level: assert property (i_smp_valid |=> o_zero_cross_out == !$past(i_smp[SAMPLE_W-1])) else $error("zx");
  a_zx_quiet: assert property (!i_smp_valid |=> $stable(o_zero_cross_out)) else $error("zx hold");
  a_to_width: assert property (s_rd(ADDR_ZERO_CROSS_TIMEOUT) |=> o_rdata[15:12] == 4'h0) else $error("timeout rd");
  a_per_msb: assert property (s_rd(ADDR_PERIOD) |=> !o_rdata[15]) else $error("period msb");
endmodule : lvsup_top_monitor
bind lvsup_top lvsup_top_monitor #(.SAMPLE_W(SAMPLE_W)) u_mon (.i_clk, .i_rst, .i_smp_valid, .i_undervolt, .i_wr,
  .i_rd, .o_zero_cross_out, .o_dip_n, .o_irq_n, .o_integrator_en, .o_accum_en, .i_smp, .i_addr, .i_wdata, .o_rdata);

// file: sim/lvsup_host.sv
// host model driving the register port
`timescale 1ns/1ps
module lvsup_host import lvsup_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr, o_rd,
  output logic [5:0]       o_addr,
  output logic [15:0]      o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = '0;
  // cycle count below two is never sent
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr <= 1'h1; o_addr <= a; o_wdata <= (a == ADDR_DIPCYC && d < 16'h0002) ? 16'h0002 : d;
    @(posedge i_clk);
    o_wr <= 1'h0; #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_rd <= 1'h1; o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'h0; #1 d = i_rdata;
  endtask : rd
endmodule : lvsup_host

// file: sim/lvsup_top_tb.sv
// self-checking bench for the line voltage supervisor
`timescale 1ns/1ps
module lvsup_top_tb;
  import lvsup_pkg::*;
  logic i_clk, i_rst, i_smp_valid, i_undervolt, i_wr, i_rd, o_zx, o_dip_n, o_irq_n, o_integ, o_accum;
  logic [15:0] i_smp, i_wdata, o_rdata, r;
  logic [5:0] i_addr;
  int bad_count = 0, n_checks = 0, cyc = 0;
  lvsup_top DUT (.i_clk, .i_rst, .i_smp_valid, .i_smp, .i_undervolt, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
    .o_zero_cross_out(o_zx), .o_dip_n, .o_irq_n, .o_integrator_en(o_integ), .o_accum_en(o_accum));
  lvsup_host h (.i_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  initial
  begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    bad_count += int'(got !== exp);
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic smp(input logic [15:0] v);
    @(posedge i_clk);
    i_smp_valid <= 1'h1; i_smp <= v;
    @(posedge i_clk);
    i_smp_valid <= 1'h0; #1;
  endtask : smp
  // n full cycles, falling then rising crossing
  task automatic wave(input logic [15:0] a, input int n);
    for (int k = 0; k < 2 * n; k++) smp(k[0] ? a : -a);
  endtask : wave
  task automatic t_defaults();
    h.rd(ADDR_ZERO_CROSS_TIMEOUT, r); chk(r, 16'h0FFF);
    chk(o_integ, 1'h0);
    h.rd(6'h3F, r); chk(r, 16'h0000);
    h.wr(ADDR_OFFSET, 16'h0080); chk(o_integ, 1'h1);
  endtask : t_defaults
  task automatic t_cross();
    h.wr(ADDR_IRQEN, 16'h0004);
    smp(16'hF000); smp(16'h1000); chk(o_zx, 1'h1); chk(o_irq_n, 1'h0);
    h.rd(ADDR_STATCLR, r); chk(r[ST_ZX], 1'h1); chk(o_irq_n, 1'h1);
    h.rd(ADDR_STATUS, r); chk(r, 16'h0000);
    smp(16'hF000); chk(o_zx, 1'h0);
  endtask : t_cross
  task automatic t_timeout();
    h.wr(ADDR_ZERO_CROSS_TIMEOUT, 16'h0002); h.rd(ADDR_ZERO_CROSS_TIMEOUT, r); chk(r, 16'h0002);
    h.wr(ADDR_IRQEN, 16'h0002); h.rd(ADDR_STATCLR, r);
    smp(16'h1000); repeat (100) @(posedge i_clk); chk(o_dip_n, 1'h1);
    repeat (200) @(posedge i_clk); chk(o_dip_n, 1'h0); chk(o_irq_n, 1'h0);
    h.rd(ADDR_STATCLR, r); chk(r[ST_CROSSING_TIMEOUT_FLAG], 1'h1);
    h.wr(ADDR_MODE, 16'h0001); h.wr(ADDR_IRQEN, 16'h0000);
    smp(16'hF000); repeat (300) @(posedge i_clk); chk(o_dip_n, 1'h1); chk(o_irq_n, 1'h1);
    h.rd(ADDR_STATCLR, r); chk(r[ST_CROSSING_TIMEOUT_FLAG], 1'h1);
    h.wr(ADDR_MODE, 16'h0000); h.wr(ADDR_ZERO_CROSS_TIMEOUT, 16'h0FFF);
  endtask : t_timeout
  task automatic t_dip();
    h.wr(ADDR_DIPCYC, 16'h0003); h.wr(ADDR_IRQEN, 16'h0001);
    smp(16'h4000); h.rd(ADDR_STATCLR, r);
    wave(16'h0100, 1); chk(o_dip_n, 1'h1);
    wave(16'h0100, 1); chk(o_dip_n, 1'h0); chk(o_irq_n, 1'h0);
    h.rd(ADDR_STATCLR, r); chk(r[ST_DIP], 1'h1);
    smp(16'h4000); chk(o_dip_n, 1'h1);
    h.wr(ADDR_DIPLVL, 16'h0002); wave(16'h0100, 3); chk(o_dip_n, 1'h1);
    h.wr(ADDR_DIPLVL, 16'h0001); wave(16'h0040, 3); chk(o_dip_n, 1'h1);
  endtask : t_dip
  task automatic t_uv();
    @(posedge i_clk);
    i_undervolt <= 1'h1; #1;
    chk(o_dip_n, 1'h0); chk(o_accum, 1'h0);
    h.rd(ADDR_PERIOD, r); chk(r[15], 1'h0);
    @(posedge i_clk);
    i_undervolt <= 1'h0;
  endtask : t_uv
  initial
  begin
    i_rst = 1'h1; i_smp_valid = 1'h0; i_smp = '0; i_undervolt = 1'h0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    t_defaults(); t_cross(); t_timeout(); t_dip(); t_uv();
    test_done();
  end
endmodule : lvsup_top_tb
